// file: verilog/u2wr_pkg.sv
package u2wr_pkg;

  // Serial mode field codes.
  localparam logic [2:0] SMD_DISABLED   = 3'h0;
  localparam logic [2:0] SMD_CLOCK_SYNC = 3'h1;
  localparam logic [2:0] SMD_TWO_WIRE   = 3'h2;

  // Receive buffer layout.
  localparam int RB_WIDTH     = 9;
  localparam int RB_HIGH_BIT  = 8;
  localparam int BYTE_WIDTH   = 8;

  // Bit counter on the link side: none, first, seventh and eighth data bit, and ninth (acknowledge) bit.
  localparam logic [3:0] BIT_EIGHT = 4'h8;
  localparam logic [3:0] BIT_NINE  = 4'h9;
  localparam logic [3:0] BIT_SEVEN = 4'h7;
  localparam logic [3:0] BIT_ONE   = 4'h1;
  localparam logic [3:0] BIT_NONE  = 4'h0;

  // Transmit delay line stages in two-wire mode, in count source cycles; the output register adds one more.
  localparam int TX_DELAY_STAGES = 2;

  // Reset values.
  localparam logic [8:0] RB_RESET  = 9'h000;
  localparam logic       LINE_HIGH = 1'b1;

  // Byte and acknowledge bit caught on the link clock.
  typedef struct packed {
    logic [7:0] data;
    logic       ack_bit;
  } u2wr_rx_word_s;

  // Static configuration written by software.
  typedef struct packed {
    logic [2:0] serial_mode_field;
    logic       two_wire_mode_bit;
    logic       two_wire_interrupt_select;
    logic       clock_delay_select;
  } u2wr_cfg_s;

endpackage : u2wr_pkg

// file: verilog/u2wr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module u2wr_sync #(
  parameter int W = 4
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1_reg;

  if (W < 1)
  begin : g_width_check
    $error("u2wr_sync needs at least one bit");
  end

  // Two flip-flops per bit; only the second stage reads the first.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule : u2wr_sync

`default_nettype wire

// file: verilog/u2wr_link_rx.sv
`timescale 1ns/1ps
`default_nettype none

module u2wr_link_rx (
  // Link clock (serial clock line) and reset.
  input  wire logic                    link_clk,
  input  wire logic                    rst_n,
  // Mode enable from the system domain.
  input  wire logic                    mode_on_async,
  // Serial data line level.
  input  wire logic                    sda_in,
  // Held byte and event toggles toward the system domain.
  output u2wr_pkg::u2wr_rx_word_s      rx_word,
  output logic                         rise9_tgl,
  output logic                         fall9_tgl
);

  logic [1:0] mode_sync_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;

  // Mode enable is brought onto the link clock by two flip-flops.
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_sync_reg <= 2'h0;
    else
      mode_sync_reg <= {mode_sync_reg[0], mode_on_async};
  end

  // Rising edges sample the data line, count bits and hold each byte for nine clocks.
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt_reg <= u2wr_pkg::BIT_NONE;
      shift_reg   <= 8'h00;
      rx_word     <= '0;
      rise9_tgl   <= 1'b0;
    end
    else if (!mode_sync_reg[1])
      bit_cnt_reg <= u2wr_pkg::BIT_NONE;
    else if (bit_cnt_reg == u2wr_pkg::BIT_NONE || bit_cnt_reg == u2wr_pkg::BIT_NINE)
    begin
      shift_reg   <= {7'h00, sda_in};
      bit_cnt_reg <= u2wr_pkg::BIT_ONE;
    end
    else if (bit_cnt_reg < u2wr_pkg::BIT_EIGHT)
    begin
      shift_reg   <= {shift_reg[6:0], sda_in};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (bit_cnt_reg == u2wr_pkg::BIT_SEVEN)
        rx_word.data <= {shift_reg[6:0], sda_in}; // First bit lands in bit 7.
    end
    else
    begin
      rx_word.ack_bit <= sda_in;
      bit_cnt_reg     <= u2wr_pkg::BIT_NINE;
      rise9_tgl       <= ~rise9_tgl;
    end
  end

  // The falling edge that opens the ninth bit marks the early transfer.
  always_ff @(negedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      fall9_tgl <= 1'b0;
    else if (mode_sync_reg[1] && bit_cnt_reg == u2wr_pkg::BIT_EIGHT)
      fall9_tgl <= ~fall9_tgl;
  end

endmodule : u2wr_link_rx

`default_nettype wire

// file: verilog/u2wr_top.sv
`timescale 1ns/1ps
`default_nettype none

module u2wr_top (
  // System clock (count source), reset and enable.
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  // Link clock taken from the serial clock line.
  input  wire logic                  link_clk,
  // Configuration.
  input  wire u2wr_pkg::u2wr_cfg_s   cfg,
  input  wire logic                  port_output_value,
  input  wire logic                  port_direction_bit,
  // Transmit data from the shifter.
  input  wire logic                  tx_active,
  input  wire logic                  tx_data_bit,
  // Serial data line pin.
  input  wire logic                  serial_data_line_pin_in,
  output logic                       serial_data_line_pin_out,
  output logic                       serial_data_line_pin_oe,
  // Serial clock line pin.
  input  wire logic                  serial_clock_line_pin_in,
  output logic                       serial_clock_line_pin_out,
  output logic                       serial_clock_line_pin_oe,
  // Receive buffer and events.
  output logic [8:0]                 receive_buffer,
  output logic                       rx_transfer_pulse,
  output logic                       dma_request,
  // Pin read-back.
  output logic                       sda_level_read,
  output logic                       scl_level_read
);

  u2wr_pkg::u2wr_rx_word_s rx_word;
  logic                    rise9_tgl;
  logic                    fall9_tgl;
  logic [3:0]              sync_bus;
  logic                    rise_seen_reg;
  logic                    fall_seen_reg;
  logic                    rise_evt;
  logic                    fall_evt;
  logic                    i2c_on;
  logic                    clk_sync_on;
  logic                    mode_on_reg;
  logic                    sda_init_reg;
  logic [u2wr_pkg::TX_DELAY_STAGES-1:0] tx_pipe_reg;
  logic [8:0]              receive_buffer_next;
  logic                    xfer_next;
  logic                    dma_next;

  //////////////////////////////////////////////////////////////////////////////

  // Mode decode.
  assign i2c_on      = (cfg.serial_mode_field == u2wr_pkg::SMD_TWO_WIRE) && cfg.two_wire_mode_bit;
  assign clk_sync_on = (cfg.serial_mode_field == u2wr_pkg::SMD_CLOCK_SYNC);

  // Registered mode enable, so the link side never synchronises a decode glitch.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_on_reg <= 1'b0;
    else if (ce)
      mode_on_reg <= i2c_on;
  end

  // Link-side receiver clocked by the serial clock line.
  u2wr_link_rx u_link (
    .link_clk      (link_clk),
    .rst_n         (rst_n),
    .mode_on_async (mode_on_reg),
    .sda_in        (serial_data_line_pin_in),
    .rx_word       (rx_word),
    .rise9_tgl     (rise9_tgl),
    .fall9_tgl     (fall9_tgl)
  );

  // Toggles and pin levels cross into the system domain.
  u2wr_sync #(
    .W (4)
  ) u_sync (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .async_in ({rise9_tgl, fall9_tgl, serial_data_line_pin_in, serial_clock_line_pin_in}),
    .sync_out (sync_bus)
  );

  //////////////////////////////////////////////////////////////////////////////

  // Last seen toggle values for edge detection.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rise_seen_reg <= 1'b0;
      fall_seen_reg <= 1'b0;
    end
    else if (ce)
    begin
      rise_seen_reg <= sync_bus[3];
      fall_seen_reg <= sync_bus[2];
    end
  end

  // One system cycle per link event; the held byte is stable for nine link clocks.
  assign rise_evt = ce && i2c_on && (sync_bus[3] != rise_seen_reg);
  assign fall_evt = ce && i2c_on && (sync_bus[2] != fall_seen_reg);

  //////////////////////////////////////////////////////////////////////////////

  // Buffer packing and DMA source for each interrupt select and delay setting.
  always_comb
  begin
    receive_buffer_next = receive_buffer;
    xfer_next           = 1'b0;
    dma_next            = 1'b0;
    if (!cfg.two_wire_interrupt_select)
    begin
      if (rise_evt)
      begin
        receive_buffer_next = {1'b0, rx_word.data};
        xfer_next           = 1'b1;
        dma_next            = !rx_word.ack_bit;
      end
    end
    else
    begin
      // Both edges of the ninth bit may land in one cycle; the later transfer then wins.
      if (fall_evt)
      begin
        receive_buffer_next = {rx_word.data[0], 1'b0, rx_word.data[7:1]};
        xfer_next           = 1'b1;
        dma_next            = 1'b1;
      end
      if (rise_evt && cfg.clock_delay_select)
      begin
        receive_buffer_next = {1'b0, rx_word.data};
        xfer_next           = 1'b1;
      end
    end
  end

  // Receive buffer, transfer pulse and DMA request registers.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      receive_buffer    <= u2wr_pkg::RB_RESET;
      rx_transfer_pulse <= 1'b0;
      dma_request       <= 1'b0;
    end
    else if (ce)
    begin
      receive_buffer    <= receive_buffer_next;
      rx_transfer_pulse <= xfer_next;
      dma_request       <= dma_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Start value of the data line is taken from the port only while disabled.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      sda_init_reg <= u2wr_pkg::LINE_HIGH;
    else if (ce && cfg.serial_mode_field == u2wr_pkg::SMD_DISABLED)
      sda_init_reg <= port_output_value;
  end

  // The delay line needs at least two stages for its shift slice.
  if (u2wr_pkg::TX_DELAY_STAGES < 2)
  begin : g_delay_check
    $error("u2wr_top needs at least two transmit delay stages");
  end

  // Transmit delay line used in two-wire mode.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_pipe_reg <= '1;
    else if (ce)
      tx_pipe_reg <= {tx_pipe_reg[u2wr_pkg::TX_DELAY_STAGES-2:0], tx_data_bit};
  end

  // Data line drive: start value when idle in two-wire mode, high when idle in other modes; delayed data in two-wire mode.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_data_line_pin_out <= u2wr_pkg::LINE_HIGH;
      serial_data_line_pin_oe  <= 1'b0;
    end
    else if (ce)
    begin
      serial_data_line_pin_oe <= i2c_on || clk_sync_on;
      if (!tx_active)
        serial_data_line_pin_out <= i2c_on ? sda_init_reg : u2wr_pkg::LINE_HIGH;
      else if (i2c_on)
        serial_data_line_pin_out <= tx_pipe_reg[u2wr_pkg::TX_DELAY_STAGES-1];
      else
        serial_data_line_pin_out <= tx_data_bit;
    end
  end

  // Clock line idle level in two-wire mode is the inverse of the clock delay select.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_clock_line_pin_out <= u2wr_pkg::LINE_HIGH;
      serial_clock_line_pin_oe  <= 1'b0;
    end
    else if (ce)
    begin
      serial_clock_line_pin_oe  <= i2c_on;
      serial_clock_line_pin_out <= i2c_on ? !cfg.clock_delay_select : u2wr_pkg::LINE_HIGH;
    end
  end

  // Pin read-back: always in two-wire mode, else only with direction cleared.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_level_read <= 1'b0;
      scl_level_read <= 1'b0;
    end
    else if (ce)
    begin
      sda_level_read <= (i2c_on || !port_direction_bit) ? sync_bus[1] : 1'b0;
      scl_level_read <= (i2c_on || !port_direction_bit) ? sync_bus[0] : 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Checks on the system clock.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  ack_transfer_a: assert property (
    rise_evt && !cfg.two_wire_interrupt_select |=>
      rx_transfer_pulse && receive_buffer[7:0] == $past(rx_word.data))
    else $error("Acknowledge-mode transfer missing.");

  first_bit_msb_a: assert property (
    rise_evt && !cfg.two_wire_interrupt_select |=>
      receive_buffer[7] == $past(rx_word.data[7]) && !receive_buffer[8])
    else $error("First received bit not in bit 7.");

  split_pack_a: assert property (
    fall_evt && cfg.two_wire_interrupt_select &&
      !(rise_evt && cfg.clock_delay_select) |=>
      receive_buffer[8] == $past(rx_word.data[0]) && receive_buffer[6:0] == $past(rx_word.data[7:1]))
    else $error("Split packing wrong.");

  no_rise_xfer_a: assert property (
    rise_evt && !fall_evt && cfg.two_wire_interrupt_select && !cfg.clock_delay_select |=>
      !rx_transfer_pulse)
    else $error("Unexpected rising-edge transfer.");

  second_xfer_a: assert property (
    rise_evt && !fall_evt && cfg.two_wire_interrupt_select && cfg.clock_delay_select |=>
      rx_transfer_pulse && receive_buffer == {1'b0, $past(rx_word.data)})
    else $error("Second transfer missing.");

  dma_source_a: assert property (
    (fall_evt && cfg.two_wire_interrupt_select) or
    (rise_evt && !cfg.two_wire_interrupt_select && !rx_word.ack_bit) |=> dma_request)
    else $error("DMA request missing.");

  scl_idle_a: assert property (
    ce && i2c_on ##1 ce |-> serial_clock_line_pin_out == !$past(cfg.clock_delay_select))
    else $error("Clock idle level wrong.");

  sda_start_a: assert property (
    ce && i2c_on && !tx_active |=> serial_data_line_pin_out == $past(sda_init_reg))
    else $error("Data start value wrong.");

  readback_a: assert property (
    ce && i2c_on |=> sda_level_read == $past(sync_bus[1]) && scl_level_read == $past(sync_bus[0]))
    else $error("Pin read-back blocked.");

  read_blocked_a: assert property (
    ce && !i2c_on && port_direction_bit |=> !sda_level_read && !scl_level_read)
    else $error("Pin read-back not blocked.");

  tx_delay_a: assert property (
    (ce && i2c_on && tx_active) [*3] |-> serial_data_line_pin_out == $past(tx_data_bit, 3))
    else $error("Transmit delay wrong.");

  ack_mode_cov: cover property (rise_evt && !cfg.two_wire_interrupt_select);
  two_step_cov: cover property (fall_evt && cfg.clock_delay_select ##[1:40] rise_evt);
  dma_cov: cover property (dma_request);
  split_cov: cover property (fall_evt && !cfg.clock_delay_select);
  tx_delay_cov: cover property (ce && i2c_on && tx_active ##1 tx_active);

endmodule : u2wr_top

`default_nettype wire

// file: verif/u2wr_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////
// Far-side bus master: makes the serial clock in frames and in single pulses,
// and releases both lines to their pull-ups in between.
module u2wr_bus_model (
  // Levels that the far side puts on the open-drain lines.
  output logic scl_drv,
  output logic sda_drv
);

  // Both lines start released, so the pull-ups hold them high.
  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  // One clock pulse of 64 ns; data changes only while the clock is low.
  task automatic pulse(input logic bit_val);
    scl_drv = 1'b0;
    sda_drv = bit_val;
    #32;
    scl_drv = 1'b1;
    #32;
  endtask : pulse

  // Eight data bits, first bit the most significant, then the acknowledge bit.
  task automatic send_frame(input logic [7:0] data, input logic ack_bit);
    for (int i = 7; i >= 0; i--)
    begin
      pulse(data[i]);
    end
    pulse(ack_bit);
    #32;
    sda_drv = 1'b1; // Released after the hold time, pull-up wins.
  endtask : send_frame

endmodule : u2wr_bus_model

`default_nettype wire

// file: verif/test_uart_i2c_mode_receive_and_pins.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////
module test_uart_i2c_mode_receive_and_pins;

  // Stimulus, observed outputs and bookkeeping.
  logic                sys_clk;
  logic                rst_n;
  logic                ce;
  logic                port_output_value;
  logic                port_direction_bit;
  logic                tx_active;
  logic                tx_data_bit;
  u2wr_pkg::u2wr_cfg_s cfg;
  logic                sda_out;
  logic                sda_oe;
  logic                scl_out;
  logic                scl_oe;
  logic [8:0]          receive_buffer;
  logic                rx_transfer_pulse;
  logic                dma_request;
  logic                sda_level_read;
  logic                scl_level_read;
  wire logic           scl_drv;
  wire logic           sda_drv;
  wire logic           sda_wire;
  wire logic           scl_wire;
  int                  miscompares;
  int                  n_compared;
  logic [9:0]          events_q[$];

  // Open-drain lines: a party driving low wins, pull-ups otherwise.
  assign sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1);
  assign scl_wire = scl_drv & (scl_oe ? scl_out : 1'b1);

  u2wr_bus_model u_bus (.scl_drv(scl_drv), .sda_drv(sda_drv));

  u2wr_top u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .link_clk(scl_drv), .cfg(cfg),
    .port_output_value(port_output_value), .port_direction_bit(port_direction_bit),
    .tx_active(tx_active), .tx_data_bit(tx_data_bit),
    .serial_data_line_pin_in(sda_wire), .serial_data_line_pin_out(sda_out),
    .serial_data_line_pin_oe(sda_oe), .serial_clock_line_pin_in(scl_wire),
    .serial_clock_line_pin_out(scl_out), .serial_clock_line_pin_oe(scl_oe),
    .receive_buffer(receive_buffer), .rx_transfer_pulse(rx_transfer_pulse),
    .dma_request(dma_request), .sda_level_read(sda_level_read),
    .scl_level_read(scl_level_read)
  );

  // System clock of 50 ns.
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  // Every buffer transfer or DMA pulse is logged with both values.
  always @(negedge sys_clk)
    if (rx_transfer_pulse === 1'b1 || dma_request === 1'b1)
      events_q.push_back({dma_request, receive_buffer});

  ////////////////////////////////////////////////////////////
  // Comparison, mode setting and frame helpers.
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic set_mode(input logic [2:0] field, input logic two, input logic sel,
                          input logic dly);
    @(negedge sys_clk);
    cfg = '{field, two, sel, dly};
    repeat (4) @(negedge sys_clk);
  endtask : set_mode

  // Mode off clears the bit counter; two link edges then arm it again.
  task automatic start_link(input logic sel, input logic dly);
    set_mode(u2wr_pkg::SMD_DISABLED, 1'b1, sel, dly);
    repeat (3) u_bus.pulse(1'b1);
    set_mode(u2wr_pkg::SMD_TWO_WIRE, 1'b1, sel, dly);
    repeat (2) u_bus.pulse(1'b1);
    check("clock idle level", {9'h000, !dly}, scl_out);
    check("clock drive", 10'h001, scl_oe);
    repeat (8) @(negedge sys_clk);
    events_q.delete();
  endtask : start_link

  task automatic frame(input logic [7:0] data, input logic ack, input int n,
                       input logic [9:0] e0, input logic [9:0] e1);
    u_bus.send_frame(data, ack);
    repeat (12) @(negedge sys_clk);
    check("transfer count", 10'(n), 10'(events_q.size()));
    if (n > 0 && events_q.size() > 0)
      check("first transfer", e0, events_q[0]);
    if (n > 1 && events_q.size() > 1)
      check("second transfer", e1, events_q[1]);
    events_q.delete();
  endtask : frame

  // Transmit output must follow the data bit after lat cycles.
  task automatic tx_delay(input logic [2:0] field, input logic two, input int lat);
    set_mode(field, two, 1'b0, 1'b0);
    tx_active = 1'b1;
    repeat (4) @(negedge sys_clk);
    tx_data_bit = 1'b0;
    for (int k = 1; k <= 4; k++)
    begin
      @(negedge sys_clk);
      tx_data_bit = 1'b1;
      check("transmit output", {9'h000, k != lat}, sda_out);
    end
    tx_active = 1'b0;
  endtask : tx_delay

  // Pin levels are blocked in clock-sync mode until the direction bit clears.
  task automatic read_back;
    set_mode(u2wr_pkg::SMD_CLOCK_SYNC, 1'b0, 1'b0, 1'b0);
    check("data read blocked", 10'h000, sda_level_read);
    check("clock read blocked", 10'h000, scl_level_read);
    port_direction_bit = 1'b0;
    repeat (4) @(negedge sys_clk);
    check("data read open", 10'h001, sda_level_read);
    check("clock read open", 10'h001, scl_level_read);
    port_direction_bit = 1'b1;
    $display("test read_back done");
  endtask : read_back

  // The data start value is taken while disabled and kept in two-wire mode.
  task automatic start_value;
    set_mode(u2wr_pkg::SMD_DISABLED, 1'b1, 1'b0, 1'b0);
    port_output_value = 1'b0;
    repeat (4) @(negedge sys_clk);
    set_mode(u2wr_pkg::SMD_TWO_WIRE, 1'b1, 1'b0, 1'b0);
    port_output_value = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("data start value", 10'h000, sda_out);
    check("data drive", 10'h001, sda_oe);
    check("data read in two-wire", 10'h000, sda_level_read);
    check("clock read in two-wire", 10'h001, scl_level_read);
    $display("test start_value done");
  endtask : start_value

  // With the enable low nothing moves; the clock idle level follows once it rises.
  task automatic clock_enable;
    @(negedge sys_clk);
    ce = 1'b0;
    cfg.clock_delay_select = 1'b1;
    repeat (4) @(negedge sys_clk);
    check("clock level frozen", 10'h001, scl_out);
    ce = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("clock level released", 10'h000, scl_out);
    $display("test clock_enable done");
  endtask : clock_enable

  ////////////////////////////////////////////////////////////
  // Main sequence: reset, then one task per scenario.
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    cfg = '0;
    port_output_value = 1'b1;
    port_direction_bit = 1'b1;
    tx_active = 1'b0;
    tx_data_bit = 1'b1;
    miscompares = 0;
    n_compared = 0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    start_link(1'b0, 1'b0);
    frame(8'ha5, 1'b0, 1, 10'h2a5, 10'h000);
    frame(8'h3c, 1'b1, 1, 10'h03c, 10'h000);
    start_link(1'b0, 1'b1);
    frame(8'h81, 1'b0, 1, 10'h281, 10'h000);
    $display("test ack_select done");
    start_link(1'b1, 1'b0);
    frame(8'ha5, 1'b1, 1, 10'h352, 10'h000);
    frame(8'h01, 1'b0, 1, 10'h300, 10'h000);
    $display("test split_packing done");
    start_link(1'b1, 1'b1);
    frame(8'ha5, 1'b1, 2, 10'h352, 10'h0a5);
    frame(8'hc3, 1'b0, 2, 10'h361, 10'h0c3);
    $display("test clock_delay done");
    tx_delay(u2wr_pkg::SMD_TWO_WIRE, 1'b1, 3);
    tx_delay(u2wr_pkg::SMD_CLOCK_SYNC, 1'b0, 1);
    $display("test transmit_delay done");
    read_back();
    start_value();
    clock_enable();
    final_report();
  end

  // The whole run needs some 17 us; stop a hang well after that.
  initial
  begin
    #200_000;
    miscompares++;
    final_report();
  end

endmodule : test_uart_i2c_mode_receive_and_pins

`default_nettype wire
